/* hw/drc_consts.vh */
// constants for the disturbance recorder capture block
`ifndef DRC_CONSTS_VH
`define DRC_CONSTS_VH
`define DRC_CLK_MHZ        250
`define DRC_DIG_PERIOD_MS  5
`define DRC_DIG_PERIOD_CYC (`DRC_DIG_PERIOD_MS * 1000 * `DRC_CLK_MHZ)
`define DRC_PRE_DEF_MS     200
`define DRC_LEN_DEF_MS     1000
`define DRC_SR_64          2'h0
`define DRC_SR_32          2'h1
`define DRC_SR_16          2'h2
`define DRC_SR_8           2'h3
`define DRC_SR_DEF         2'h0
`define DRC_MAX_ANA        8
`define DRC_MAX_DIG        95
`define DRC_WORD_BYTES     4
`define DRC_STORE_BYTES    64306588
`define DRC_DIG_RATE_HZ    200
`define DRC_XFER_MAX       6
`define DRC_MAX_RECS       100
`define DRC_EV_TRIG_ON     4'h1
`define DRC_EV_TRIG_OFF    4'h2
`define DRC_EV_ALL_CLR     4'h3
`define DRC_EV_OLD_CLR     4'h4
`define DRC_EV_FULL_ON     4'h5
`define DRC_EV_FULL_OFF    4'h6
`define DRC_EV_REC_ON      4'h7
`define DRC_EV_REC_OFF     4'h8
`define DRC_EV_STO_ON      4'h9
`define DRC_EV_STO_OFF     4'h0a
`define DRC_EV_NEW_CLR     4'h0b
`endif

/* hw/drc_sample_timer.v */
// sample strobe generator: divides the clock down to a tick period
`timescale 1ns/1ps
module drc_sample_timer #(
   parameter W = 32
) (
   input  wire         mclk_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] period_i,
   output reg          tick_o
);
   reg [W-1:0] cnt_reg;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= {W{1'b0}};
         tick_o  <= 1'b0;
      end else if (cnt_reg + {{(W-1){1'b0}}, 1'b1} >= period_i) begin
         cnt_reg <= {W{1'b0}};
         tick_o  <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
         tick_o  <= 1'b0;
      end
   end
endmodule // drc_sample_timer

/* hw/drc_sync2.v */
// two flip-flop synchroniser for a bus of levels from outside the domain
`timescale 1ns/1ps
module drc_sync2 #(
   parameter W = 1
) (
   input  wire         mclk_i,
   input  wire         rst_n_i,
   input  wire [W-1:0] d_i,
   output reg  [W-1:0] q_o
);
   reg [W-1:0] meta_reg;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= {W{1'b0}};
         q_o      <= {W{1'b0}};
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule // drc_sync2

/* hw/drc_recorder.v */
// disturbance recorder capture: history, trigger, storage, transfer, events
`timescale 1ns/1ps
`include "drc_consts.vh"
module drc_recorder #(
   parameter NTRIG     = 16,
   parameter DIG_CYC   = `DRC_DIG_PERIOD_CYC,
   parameter CAP_WORDS = `DRC_STORE_BYTES / `DRC_WORD_BYTES
) (
   input  wire        mclk_i,
   input  wire        rst_n_i,
   input  wire        enable_i,
   input  wire [1:0]  sample_rate_i,
   input  wire [7:0]  nominal_hz_i,
   input  wire [3:0]  ana_count_i,
   input  wire [6:0]  dig_count_i,
   input  wire [15:0] pre_ms_i,
   input  wire [20:0] len_ms_i,
   input  wire        keep_olds_i,
   input  wire        auto_xfer_i,
   input  wire [NTRIG-1:0] trig_sel_i,
   input  wire [NTRIG-1:0] trig_src_i,
   input  wire        manual_trig_i,
   input  wire        clear_all_i,
   input  wire        clear_oldest_i,
   input  wire        clear_newest_i,
   input  wire        xfer_removed_i,
   input  wire        manual_get_i,
   input  wire [31:0] time_i,
   output reg         ana_strobe_o,
   output reg         dig_strobe_o,
   output reg         ready_o,
   output reg         triggered_o,
   output reg         recording_o,
   output reg         storing_o,
   output reg         full_o,
   output reg  [6:0]  recs_o,
   output reg  [2:0]  xfer_held_o,
   output reg         xfer_push_o,
   output reg         get_valid_o,
   output reg  [6:0]  get_count_o,
   output reg  [31:0] max_len_ms_o,
   output reg  [31:0] total_words_o,
   output reg         event_valid_o,
   output reg  [3:0]  event_code_o,
   output reg  [31:0] event_time_o,
   output reg         manual_trig_ack_o
);
   localparam ST_IDLE  = 4'b0001;
   localparam ST_ARMED = 4'b0010;
   localparam ST_POST  = 4'b0100;
   localparam ST_STORE = 4'b1000;
   // parameters are untyped integers; fixed-width copies keep the math exact
   localparam [31:0] CLK_HZ   = `DRC_CLK_MHZ * 1000000;
   localparam [31:0] DIG_PER  = DIG_CYC;
   localparam [31:0] CAP_W32  = CAP_WORDS;
   localparam [63:0] CAP_W64  = CAP_WORDS;
   localparam [63:0] MAX_RECS = `DRC_MAX_RECS;
   // words per analog instant: selected channels plus one time stamp word
   function [31:0] words_per_inst;
      input [3:0] na;
      begin
         words_per_inst = {28'h0, na} + 32'h1;
      end
   endfunction
   function [31:0] spc;
      input [1:0] sel;
      begin
         case (sel)
            `DRC_SR_32: spc = 32'h20;
            `DRC_SR_16: spc = 32'h10;
            `DRC_SR_8:  spc = 32'h8;
            default:    spc = 32'h40;
         endcase
      end
   endfunction
   wire [NTRIG-1:0] trig_s;
   wire [2:0]       cmd_s;
   drc_sync2 #(.W(NTRIG)) u_sync_trig (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .d_i     (trig_src_i),
      .q_o     (trig_s)
   );
   drc_sync2 #(.W(3)) u_sync_cmd (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({manual_trig_i, xfer_removed_i, manual_get_i}),
      .q_o     (cmd_s)
   );
   // analog period in clocks = 250e6 / (fn * spc)
   reg  [31:0] ana_period_reg;
   wire        ana_tick;
   wire        dig_tick;
   drc_sample_timer #(.W(32)) u_ana_tmr (
      .mclk_i   (mclk_i),
      .rst_n_i  (rst_n_i),
      .period_i (ana_period_reg),
      .tick_o   (ana_tick)
   );
   drc_sample_timer #(.W(32)) u_dig_tmr (
      .mclk_i   (mclk_i),
      .rst_n_i  (rst_n_i),
      .period_i (DIG_PER),
      .tick_o   (dig_tick)
   );
   // capacity math; wide products are cut deliberately
   reg  [63:0] rate_reg;
   reg  [63:0] rec_words_reg;
   reg  [31:0] max_recs_reg;
   wire [3:0]  na = (ana_count_i > 4'd8) ? 4'd8 : ana_count_i;
   wire [6:0]  nd = (dig_count_i > 7'd95) ? 7'd95 : dig_count_i;
   wire        trig_any = |trig_sel_i;
   wire [63:0] fn_spc = {56'h0, nominal_hz_i} * {32'h0, spc(sample_rate_i)};
   wire [63:0] rate_next = fn_spc * {32'h0, words_per_inst(na)}
                         + 64'd200 * {57'h0, nd};
   // quotients are guarded against a zero divisor and cut to 32 bits below
   wire [63:0] recs_fit = (rec_words_reg == 64'h0) ? 64'h0 :
                          CAP_W64 / rec_words_reg;
   wire [63:0] len_fit  = (rate_reg == 64'h0) ? 64'h0 :
                          (CAP_W64 * 64'd1000) / rate_reg;
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ana_period_reg <= 32'h0;
         rate_reg       <= 64'h0;
         rec_words_reg  <= 64'h0;
         max_recs_reg   <= 32'h0;
         total_words_o  <= 32'h0;
         max_len_ms_o   <= 32'h0;
         ready_o        <= 1'b0;
      end else begin
         ana_period_reg <= (fn_spc == 64'h0) ? 32'h1 :
                           CLK_HZ / fn_spc[31:0];
         rate_reg       <= rate_next;
         rec_words_reg  <= (rate_reg * {43'h0, len_ms_i}) / 64'd1000;
         max_recs_reg   <= (recs_fit > MAX_RECS) ? MAX_RECS[31:0] :
                           recs_fit[31:0];
         total_words_o  <= CAP_W32;
         // total recording time in ms, zero while no trigger is selected
         max_len_ms_o   <= !trig_any ? 32'h0 : len_fit[31:0];
         ready_o        <= enable_i && trig_any;
      end
   end
   // circular history: a write pointer over the store, in words
   reg  [3:0]  st_reg;
   reg  [31:0] wr_ptr_reg;
   reg  [31:0] post_left_reg;
   reg  [6:0]  xfer_ok_reg;
   wire        trig_hit = (|(trig_s & trig_sel_i)) | cmd_s[2];
   wire [63:0] pre_w = (rate_reg * {48'h0, pre_ms_i}) / 64'd1000;
   wire        room = (max_recs_reg != 32'h0) &&
                      ({25'h0, recs_o} < max_recs_reg);
   wire        trig_go   = trig_hit && (room || !keep_olds_i);
   wire        post_end  = ana_tick &&
                           (post_left_reg <= words_per_inst(na));
   wire        one_ok    = recs_o > xfer_ok_reg;
   wire        store_new = (st_reg == ST_STORE) && auto_xfer_i;
   wire        full_cond = (max_recs_reg != 32'h0) && !room;
   // a clear waits here while a state event owns the cycle, so that
   // neither the clear nor any event is ever dropped
   reg  [2:0]  clr_pend_reg;
   wire [2:0]  clr_req   = clr_pend_reg |
                           {clear_all_i, clear_oldest_i, clear_newest_i};
   // finished recordings not yet pushed wait while the area holds six
   reg  [6:0]  xfer_pend_reg;
   wire        push_go   = auto_xfer_i && !cmd_s[1] && xfer_held_o < 3'd6 &&
                           (xfer_pend_reg != 7'h0 || store_new);
   reg         st_ev;
   reg  [3:0]  st_code;
   reg         clr_go;
   reg         full_go;
   reg         ev_fire;
   reg  [3:0]  ev_code;
   // one event per cycle: a state change first, then a clear, then full
   always @* begin
      st_ev   = 1'b0;
      st_code = 4'h0;
      case (st_reg)
         ST_IDLE: begin
            if (ready_o) begin
               st_ev   = 1'b1;
               st_code = `DRC_EV_REC_ON;
            end
         end
         ST_ARMED: begin
            if (triggered_o) begin
               st_ev   = 1'b1;
               st_code = `DRC_EV_TRIG_OFF;
            end else if (!ready_o) begin
               st_ev   = 1'b1;
               st_code = `DRC_EV_REC_OFF;
            end else if (trig_go) begin
               st_ev   = 1'b1;
               st_code = `DRC_EV_TRIG_ON;
            end
         end
         ST_POST: begin
            if (post_end) begin
               st_ev   = 1'b1;
               st_code = `DRC_EV_STO_ON;
            end
         end
         default: begin
            st_ev   = 1'b1;
            st_code = `DRC_EV_STO_OFF;
         end
      endcase
      // clearing one recording is refused while only pushed ones remain
      clr_go  = !st_ev &&
                (clr_req[2] || (clr_req[1:0] != 2'h0 && one_ok));
      full_go = !st_ev && !clr_go && (full_o != full_cond);
      ev_fire = st_ev || clr_go || full_go;
      if (st_ev)
         ev_code = st_code;
      else if (clr_go)
         ev_code = clr_req[2] ? `DRC_EV_ALL_CLR :
                   (clr_req[1] ? `DRC_EV_OLD_CLR : `DRC_EV_NEW_CLR);
      else if (full_go)
         ev_code = full_o ? `DRC_EV_FULL_OFF : `DRC_EV_FULL_ON;
      else
         ev_code = 4'h0;
   end
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg            <= ST_IDLE;
         wr_ptr_reg        <= 32'h0;
         post_left_reg     <= 32'h0;
         recs_o            <= 7'h0;
         xfer_held_o       <= 3'h0;
         xfer_push_o       <= 1'b0;
         xfer_ok_reg       <= 7'h0;
         xfer_pend_reg     <= 7'h0;
         clr_pend_reg      <= 3'h0;
         triggered_o       <= 1'b0;
         recording_o       <= 1'b0;
         storing_o         <= 1'b0;
         full_o            <= 1'b0;
         get_valid_o       <= 1'b0;
         get_count_o       <= 7'h0;
         ana_strobe_o      <= 1'b0;
         dig_strobe_o      <= 1'b0;
         manual_trig_ack_o <= 1'b0;
         event_valid_o     <= 1'b0;
         event_code_o      <= 4'h0;
         event_time_o      <= 32'h0;
      end else begin
         xfer_push_o       <= push_go;
         manual_trig_ack_o <= 1'b0;
         get_valid_o       <= 1'b0;
         ana_strobe_o      <= ana_tick && st_reg != ST_IDLE;
         dig_strobe_o      <= dig_tick && st_reg != ST_IDLE;
         if (ana_tick && st_reg != ST_IDLE)
            wr_ptr_reg <= (wr_ptr_reg + words_per_inst(na) >= CAP_W32) ?
                          32'h0 : wr_ptr_reg + words_per_inst(na);
         if (cmd_s[0]) begin
            get_valid_o <= 1'b1;
            get_count_o <= recs_o - xfer_ok_reg;
         end
         // a removal right after a push would drop one the client never saw
         if (push_go)
            xfer_held_o <= xfer_held_o + 3'h1;
         else if (cmd_s[1] && !xfer_push_o)
            xfer_held_o <= 3'h0;
         xfer_pend_reg <= xfer_pend_reg + {6'h0, store_new} -
                          {6'h0, push_go};
         if (push_go)
            xfer_ok_reg <= xfer_ok_reg + 7'h1;
         case (st_reg)
            ST_IDLE: begin
               if (ready_o) begin
                  st_reg      <= ST_ARMED;
                  recording_o <= 1'b1;
               end
            end
            ST_ARMED: begin
               if (triggered_o)
                  triggered_o <= 1'b0;
               else if (!ready_o) begin
                  st_reg      <= ST_IDLE;
                  recording_o <= 1'b0;
               end else if (trig_go) begin
                  st_reg            <= ST_POST;
                  triggered_o       <= 1'b1;
                  manual_trig_ack_o <= cmd_s[2];
                  post_left_reg     <= (rec_words_reg > pre_w) ?
                        rec_words_reg[31:0] - pre_w[31:0] : 32'h1;
               end
            end
            ST_POST: begin
               if (post_end) begin
                  st_reg    <= ST_STORE;
                  storing_o <= 1'b1;
               end else if (ana_tick)
                  post_left_reg <= post_left_reg - words_per_inst(na);
            end
            default: begin
               st_reg    <= ST_ARMED;
               storing_o <= 1'b0;
               // fifo mode: oldest dropped, count unchanged
               if (room)
                  recs_o <= recs_o + 7'h1;
            end
         endcase
         if (st_ev)
            clr_pend_reg <= clr_req;
         else if (clr_req[1] && !clr_req[2] && one_ok)
            clr_pend_reg <= {2'h0, clr_req[0]};
         else
            clr_pend_reg <= 3'h0;
         if (clr_go && clr_req[2]) begin
            recs_o      <= 7'h0;
            xfer_ok_reg <= 7'h0;
         end else if (clr_go)
            recs_o <= recs_o - 7'h1;
         if (full_go)
            full_o <= !full_o;
         event_valid_o <= ev_fire;
         event_code_o  <= ev_code;
         if (ev_fire)
            event_time_o <= time_i;
      end
   end
endmodule // drc_recorder

/* testbench/drc_recorder_monitor.sv */
// checker on the recorder capture ports
`timescale 1ns/1ps
module drc_recorder_monitor #(
   parameter NTRIG     = 16,
   parameter DIG_CYC   = 100,
   parameter CAP_WORDS = 16
) (
   input wire             mclk_i,
   input wire             rst_n_i,
   input wire             enable_i,
   input wire             auto_xfer_i,
   input wire [NTRIG-1:0] trig_sel_i,
   input wire [31:0]      time_i,
   input wire             dig_strobe_o,
   input wire             ready_o,
   input wire             storing_o,
   input wire             full_o,
   input wire [6:0]       recs_o,
   input wire [2:0]       xfer_held_o,
   input wire             xfer_push_o,
   input wire [31:0]      max_len_ms_o,
   input wire [31:0]      total_words_o,
   input wire             event_valid_o,
   input wire [3:0]       event_code_o,
   input wire [31:0]      event_time_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   reg [31:0] gap_reg;
   reg        seen_reg;
   // a disable stops the strobes while the recorder is idle, so spacing is not judged then
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap_reg  <= 32'h0;
         seen_reg <= 1'b0;
      end else begin
         gap_reg  <= dig_strobe_o ? 32'h1 : gap_reg + 32'h1;
         seen_reg <= enable_i & (seen_reg | dig_strobe_o);
      end
   end
   sequence s_count_moves;
      ##[1:2] (recs_o != $past(recs_o));
   endsequence
   sequence s_store_start;
      $rose(storing_o) && !full_o;
   endsequence
   chk_dig_period: assert property (
      dig_strobe_o && seen_reg |-> gap_reg == DIG_CYC)
      else $error("digital strobe spacing wrong");
   chk_not_ready: assert property (
      (trig_sel_i == 0)[*8] |-> !ready_o && max_len_ms_o == 32'h0)
      else $error("ready without a trigger source");
   chk_auto_off: assert property ((!auto_xfer_i)[*4] |-> !xfer_push_o)
      else $error("push while auto transfer off");
   chk_held_max: assert property (xfer_held_o <= 3'h6)
      else $error("transfer area above six");
   chk_push_room: assert property (
      xfer_push_o |-> $past(xfer_held_o) != 3'h6)
      else $error("push into a full transfer area");
   chk_store_count: assert property (s_store_start |-> s_count_moves)
      else $error("stored recording not counted");
   chk_event_code: assert property (
      event_valid_o |-> event_code_o inside {[4'h1:4'hb]})
      else $error("event code outside the set");
   chk_event_stamp: assert property (event_valid_o |->
      event_time_o == $past(time_i) || event_time_o == $past(time_i, 2))
      else $error("event time stamp stale");
   chk_capacity: assert property (
      ready_o |-> total_words_o == CAP_WORDS)
      else $error("capacity words wrong");
endmodule // drc_recorder_monitor

bind drc_recorder drc_recorder_monitor #(
   .NTRIG(NTRIG), .DIG_CYC(DIG_CYC), .CAP_WORDS(CAP_WORDS)
) mon_u (.mclk_i, .rst_n_i, .enable_i, .auto_xfer_i, .trig_sel_i, .time_i,
   .dig_strobe_o, .ready_o, .storing_o, .full_o, .recs_o, .xfer_held_o,
   .xfer_push_o, .max_len_ms_o, .total_words_o, .event_valid_o,
   .event_code_o, .event_time_o);

/* testbench/drc_client_model.sv */
// file client model: takes pushed recordings and removes them later
`timescale 1ns/1ps
module drc_client_model #(
   parameter DLY = 20
) (
   input  wire mclk_i,
   input  wire rst_n_i,
   input  wire push_i,
   output reg  removed_o
);
   integer wait_reg;
   // a large DLY is a slow client and lets held recordings pile up
   always @(negedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_reg  <= 0;
         removed_o <= 1'b0;
      end else begin
         removed_o <= (wait_reg == 1);
         wait_reg  <= push_i ? DLY : (wait_reg > 0 ? wait_reg - 1 : 0);
      end
   end
endmodule // drc_client_model

/* testbench/testbench.sv */
// self-checking bench for the recorder capture block
`timescale 1ns/1ps
module testbench;
   localparam DIG = 100;
   localparam CAP = 32'h00f42400;
   reg mclk_i = 1'b0, rst_n_i = 1'b0, enable_i = 1'b1, keep_olds_i = 1'b0;
   reg auto_xfer_i = 1'b1, manual_trig_i = 1'b0, manual_get_i = 1'b0;
   reg clear_all_i = 1'b0, clear_oldest_i = 1'b0, clear_newest_i = 1'b0;
   reg  [1:0]  sample_rate_i = 2'h0;
   reg  [7:0]  nominal_hz_i = 8'h32;
   reg  [3:0]  ana_count_i = 4'h3;
   reg  [6:0]  dig_count_i = 7'h10;
   reg  [15:0] pre_ms_i = 16'h0, trig_sel_i = 16'h0, trig_src_i = 16'h0;
   reg  [20:0] len_ms_i = 21'h1;
   reg  [31:0] time_i = 32'h0, rng = 32'he5300ce9;
   wire xfer_removed_i, ana_strobe_o, dig_strobe_o, ready_o, triggered_o;
   wire recording_o, storing_o, full_o, xfer_push_o, get_valid_o;
   wire event_valid_o, manual_trig_ack_o;
   wire [6:0]  recs_o, get_count_o;
   wire [2:0]  xfer_held_o;
   wire [3:0]  event_code_o;
   wire [31:0] max_len_ms_o, total_words_o, event_time_o;
   integer n_fail = 0, comparisons = 0;
   reg strict = 1'b0;
   reg [3:0] seen = 4'h0;
   reg [7:0] q[$];
   drc_recorder #(.DIG_CYC(DIG), .CAP_WORDS(CAP)) dut_u (.mclk_i, .rst_n_i,
      .enable_i, .sample_rate_i, .nominal_hz_i, .ana_count_i, .dig_count_i,
      .pre_ms_i, .len_ms_i, .keep_olds_i, .auto_xfer_i, .trig_sel_i,
      .trig_src_i, .manual_trig_i, .clear_all_i, .clear_oldest_i,
      .clear_newest_i, .xfer_removed_i, .manual_get_i, .time_i,
      .ana_strobe_o, .dig_strobe_o, .ready_o, .triggered_o, .recording_o,
      .storing_o, .full_o, .recs_o, .xfer_held_o, .xfer_push_o,
      .get_valid_o, .get_count_o, .max_len_ms_o, .total_words_o,
      .event_valid_o, .event_code_o, .event_time_o, .manual_trig_ack_o);
   drc_client_model #(.DLY(20)) client_u (.mclk_i, .rst_n_i,
      .push_i(xfer_push_o), .removed_o(xfer_removed_i));
   always #2 mclk_i = ~mclk_i;
   function [31:0] xs(input [31:0] v);
      reg [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
   endfunction
   // random stamps, so a stale stamp cannot match by luck
   always @(negedge mclk_i) begin
      rng = xs(rng);
      time_i = rng;
   end
   task chk(input [31:0] got, input [31:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task cyc(input integer n);
      repeat (n) @(negedge mclk_i);
   endtask
   // one recording: manual command when src is zero, else a source pulse
   task take_rec(input [15:0] src);
      integer k;
      begin
         manual_trig_i = (src == 16'h0);
         trig_src_i = src;
         cyc(1);
         manual_trig_i = 1'b0;
         trig_src_i = 16'h0;
         for (k = 0; k < 20000 && storing_o !== 1'b1; k = k + 1) begin
            cyc(1);
            seen = seen | {manual_trig_ack_o === 1'b1, triggered_o === 1'b1,
                           ana_strobe_o === 1'b1, recording_o === 1'b1};
         end
         cyc(2);
      end
   endtask
   always @(negedge mclk_i) begin
      if (strict && event_valid_o === 1'b1)
         chk({4'h0, event_code_o}, q.pop_front());
      if (strict && get_valid_o === 1'b1)
         chk({1'b1, get_count_o}, q.pop_front());
   end
   initial begin
      #300000;
      n_fail = n_fail + 1;
      $display("unexpected at %0t: run hung", $time);
      close_out;
   end
   initial begin : main
      integer i;
      cyc(8);
      rst_n_i = 1'b1;
      cyc(8);
      chk(ready_o, 1'b0);
      chk(max_len_ms_o, 32'h0);
      $display("test idle done");
      trig_sel_i = 16'h0001;
      cyc(8);
      chk(ready_o, 1'b1);
      chk(total_words_o, CAP);
      chk(max_len_ms_o, 32'h000f4240);
      sample_rate_i = 2'h2;
      cyc(8);
      chk(max_len_ms_o, 32'h002625a0);
      sample_rate_i = 2'h0;
      // fastest analog rate, and post-trigger span of one sample, keep
      // each recording near one analog period long
      nominal_hz_i = 8'hff;
      pre_ms_i = 16'h1;
      $display("test total time done");
      for (i = 0; i < 300 && dig_strobe_o !== 1'b1; i = i + 1)
         cyc(1);
      i = 0;
      do begin
         cyc(1);
         i = i + 1;
      end while (dig_strobe_o !== 1'b1 && i < 300);
      chk(i, DIG);
      $display("test digital rate done");
      take_rec(16'h0);
      chk(recs_o, 7'h1);
      chk(xfer_held_o, 3'h1);
      chk(seen, 4'hf);
      for (i = 0; i < 60 && xfer_held_o !== 3'h0; i = i + 1)
         cyc(1);
      chk(xfer_held_o, 3'h0);
      $display("test record done");
      auto_xfer_i = 1'b0;
      take_rec(16'h0);
      take_rec(16'h0001);
      chk(recs_o, 7'h3);
      chk(xfer_held_o, 3'h0);
      $display("test unpushed records done");
      cyc(20);
      strict = 1'b1;
      // an unselected source must raise no trigger event
      trig_src_i = 16'h0002;
      q.push_back(8'h82);
      manual_get_i = 1'b1;
      cyc(1);
      manual_get_i = 1'b0;
      trig_src_i = 16'h0;
      cyc(8);
      for (i = 0; i < 3; i = i + 1) begin
         q.push_back(i == 0 ? 8'h0b : (i == 1 ? 8'h04 : 8'h03));
         {clear_newest_i, clear_oldest_i, clear_all_i} = 3'h4 >> i;
         cyc(1);
         {clear_newest_i, clear_oldest_i, clear_all_i} = 3'h0;
         cyc(4);
      end
      chk(recs_o, 7'h0);
      chk(q.size(), 0);
      strict = 1'b0;
      $display("test clears done");
      close_out;
   end
endmodule // testbench
